/* rtl/ppa_map.vh */
`ifndef PPA_MAP_VH
`define PPA_MAP_VH
// register byte offsets
`define PPA_OFF_ADDR 12'h000
`define PPA_OFF_PEN 12'h004
`define PPA_OFF_STAT 12'h008
`define PPA_OFF_PAD 12'h00C
`define PPA_OFF_CTRL 12'h010
`define PPA_OFF_IRQ_STAT 12'h014
`define PPA_OFF_IRQ_MASK 12'h018
// address register fields
`define PPA_ADDR_TOP 15
`define PPA_ADDR_CS 14
`define PPA_ADDR_MASK 16'h3FFF
`define PPA_ADDR_IMPL 16'hFFFF
// pin enable fields
`define PPA_PEN_IMPL 16'h47FF
`define PPA_PEN_SEL 14
`define PPA_PEN_MID_MASK 16'h07FC
`define PPA_PEN_LATCH_MASK 16'h0003
// status fields
`define PPA_ST_IBF 15
`define PPA_ST_INBUF_OVERFLOW 14
`define PPA_ST_OBE 7
`define PPA_ST_OUTBUF_UNDERFLOW 6
// pad config fields
`define PPA_PAD_IMPL 16'h0003
`define PPA_PAD_TTL 0
`define PPA_PAD_CAL 1
// control register: [1:0] port mode, [3:2] select fn, [5:4] irq mode
`define PPA_CTRL_IMPL 16'h003F
`define PPA_MODE_ADDR_SLAVE 2'b01
`define PPA_CSF_SELECT 2'b10
`define PPA_IRQM_BUF3 2'b11
// irq status bits
`define PPA_IRQ_OVF 0
`define PPA_IRQ_UNF 1
`define PPA_IRQ_B3 2
`define PPA_IRQ_W 3
`endif

/* rtl/ppa_port.v */
// Functional notes
// - address register drives external address lines
// - chip select bit drives chip select active
// - pad fourteen enable: address14 or select
// - mid pad enables give address lines
// - latch pad enables: address1:0 or strobes
// - small variants omit mid address pads
// - all-full set only when all slots full
// - host write to full slot sets overflow
// - slot full set by host, cleared by read
// - all-empty status, resets to one
// - host read of empty sets underflow
// - slot empty cleared by write, reset one
// - threshold bit selects ttl or schmitt
// - calendar output select, gated by enable
// - unimplemented bits ignore writes, read zero
// - port mode 01 is addressable slave
// - select function 10 makes pad chip select
// - irq mode 11 fires on slot three access
//
// Our own choices: the register offsets and the APB interface to the registers.
`include "ppa_map.vh"
`default_nettype none
module ppa_port #(
  parameter HAS_MID_PADS = 1
) (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire host_wr_i,
  input wire host_rd_i,
  input wire [1:0] host_addr_i,
  input wire [7:0] host_data_i,
  output reg [7:0] host_data_o,
  input wire cal_second_i,
  input wire cal_alarm_i,
  input wire calendar_out_enable_i,
  output reg calendar_pin_o,
  output reg [15:0] addr_pads_o,
  output reg [15:0] addr_pad_func_o,
  output reg chip_select_out_o,
  output reg input_threshold_select_o,
  output reg irq_o
);
  reg [15:0] addr_reg;
  reg [15:0] pen_reg;
  reg [1:0] pad_reg;
  reg [5:0] ctrl_reg;
  reg [3:0] irq_stat_reg;
  reg [3:0] irq_mask_reg;
  reg [3:0] in_full_reg;
  reg [3:0] out_empty_reg;
  reg inbuf_overflow_reg;
  reg outbuf_underflow_reg;
  reg [7:0] in_buf_reg [0:3];
  reg [7:0] out_buf_reg [0:3];
  reg [2:0] wr_sync_reg;
  reg [2:0] rd_sync_reg;
  reg [1:0] ha_s1_reg;
  reg [1:0] ha_s2_reg;
  reg [7:0] hd_s1_reg;
  reg [7:0] hd_s2_reg;
  reg [1:0] wr_ptr_reg;
  reg [1:0] rd_ptr_reg;
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i;
  wire rd = acc & ~pwrite_i;
  wire [11:0] off = {paddr_i[11:2], 2'b00};
  wire mapped = (off <= `PPA_OFF_IRQ_MASK) | (off[11:4] == 8'h04);
  wire addr_slave = ctrl_reg[1:0] == `PPA_MODE_ADDR_SLAVE;
  // host strobes act on their rising edge after two flops
  wire hwr = wr_sync_reg[1] & ~wr_sync_reg[2];
  wire hrd = rd_sync_reg[1] & ~rd_sync_reg[2];
  wire [1:0] hw_slot = addr_slave ? ha_s2_reg : wr_ptr_reg;
  wire [1:0] hr_slot = addr_slave ? ha_s2_reg : rd_ptr_reg;
  wire [15:0] stat_val;
  wire [3:0] ev;
  wire [15:0] pen_eff;
  wire [15:0] mid_keep = HAS_MID_PADS ? 16'hFFFF : ~`PPA_PEN_MID_MASK;
  assign pen_eff = pen_reg & mid_keep;
  assign stat_val = {&in_full_reg, inbuf_overflow_reg, 2'b00, in_full_reg,
    &out_empty_reg, outbuf_underflow_reg, 2'b00, out_empty_reg};
  assign ev[`PPA_IRQ_OVF] = hwr & in_full_reg[hw_slot];
  assign ev[`PPA_IRQ_UNF] = hrd & out_empty_reg[hr_slot];
  assign ev[`PPA_IRQ_B3] = (ctrl_reg[5:4] == `PPA_IRQM_BUF3) &
    (hwr | hrd) & (addr_slave ? (ha_s2_reg == 2'b11) :
    (hwr ? wr_ptr_reg == 2'b11 : rd_ptr_reg == 2'b11));
  assign ev[`PPA_IRQ_W] = hwr | hrd;
  wire [1:0] cpu_slot = paddr_i[3:2];
  wire cpu_in_rd = rd & (off[11:4] == 8'h04);
  wire cpu_out_wr = wr & (off[11:4] == 8'h04);
  integer i;
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      wr_sync_reg <= 3'b000;
      rd_sync_reg <= 3'b000;
      ha_s1_reg <= 2'b00;
      ha_s2_reg <= 2'b00;
      hd_s1_reg <= 8'h00;
      hd_s2_reg <= 8'h00;
    end else begin
      wr_sync_reg <= {wr_sync_reg[1:0], host_wr_i};
      rd_sync_reg <= {rd_sync_reg[1:0], host_rd_i};
      ha_s1_reg <= host_addr_i;
      ha_s2_reg <= ha_s1_reg;
      hd_s1_reg <= host_data_i;
      hd_s2_reg <= hd_s1_reg;
    end
  end
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      addr_reg <= 16'h0000;
      pen_reg <= 16'h0000;
      pad_reg <= 2'b00;
      ctrl_reg <= 6'h00;
      irq_mask_reg <= 4'h0;
      irq_stat_reg <= 4'h0;
      in_full_reg <= 4'h0;
      out_empty_reg <= 4'hF;
      inbuf_overflow_reg <= 1'b0;
      outbuf_underflow_reg <= 1'b0;
      wr_ptr_reg <= 2'b00;
      rd_ptr_reg <= 2'b00;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      host_data_o <= 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
        in_buf_reg[i] <= 8'h00;
        out_buf_reg[i] <= 8'h00;
      end
    end else begin
      pready_o <= psel_i & ~pready_o;
      pslverr_o <= psel_i & ~pready_o & ~mapped;
      // writes mask unimplemented bits
      if (wr & pready_o) begin
        case (off)
          `PPA_OFF_ADDR: addr_reg <= pwdata_i[15:0] & `PPA_ADDR_IMPL;
          `PPA_OFF_PEN: pen_reg <= pwdata_i[15:0] & `PPA_PEN_IMPL;
          `PPA_OFF_PAD: pad_reg <= pwdata_i[1:0];
          `PPA_OFF_CTRL: ctrl_reg <= pwdata_i[5:0];
          `PPA_OFF_IRQ_MASK: irq_mask_reg <= pwdata_i[3:0];
          default: ;
        endcase
      end
      // flags: hardware set wins over software clear
      if (wr & pready_o & (off == `PPA_OFF_STAT)) begin
        if (!pwdata_i[`PPA_ST_INBUF_OVERFLOW])
          inbuf_overflow_reg <= 1'b0;
        if (!pwdata_i[`PPA_ST_OUTBUF_UNDERFLOW])
          outbuf_underflow_reg <= 1'b0;
      end
      if (ev[`PPA_IRQ_OVF])
        inbuf_overflow_reg <= 1'b1;
      if (ev[`PPA_IRQ_UNF])
        outbuf_underflow_reg <= 1'b1;
      // slot full flags
      if (cpu_in_rd & pready_o)
        in_full_reg[cpu_slot] <= 1'b0;
      if (hwr & ~in_full_reg[hw_slot]) begin
        in_full_reg[hw_slot] <= 1'b1;
        in_buf_reg[hw_slot] <= hd_s2_reg;
      end
      if (hwr & ~addr_slave)
        wr_ptr_reg <= wr_ptr_reg + 2'b01;
      // slot empty flags
      if (cpu_out_wr & pready_o) begin
        out_empty_reg[cpu_slot] <= 1'b0;
        out_buf_reg[cpu_slot] <= pwdata_i[7:0];
      end
      if (hrd) begin
        host_data_o <= out_buf_reg[hr_slot];
        out_empty_reg[hr_slot] <= 1'b1;
        if (~addr_slave)
          rd_ptr_reg <= rd_ptr_reg + 2'b01;
      end
      // read clears irq status, new events still win
      if (rd & pready_o & (off == `PPA_OFF_IRQ_STAT))
        irq_stat_reg <= ev;
      else
        irq_stat_reg <= irq_stat_reg | ev;
      // read data is latched in the setup cycle so it stands with pready
      if (psel_i & ~penable_i & ~pwrite_i & ~pready_o) begin
        case (off)
          `PPA_OFF_ADDR: prdata_o <= {16'h0000, addr_reg};
          `PPA_OFF_PEN: prdata_o <= {16'h0000, pen_reg};
          `PPA_OFF_STAT: prdata_o <= {16'h0000, stat_val};
          `PPA_OFF_PAD: prdata_o <= {30'h0000_0000, pad_reg};
          `PPA_OFF_CTRL: prdata_o <= {26'h000_0000, ctrl_reg};
          `PPA_OFF_IRQ_STAT: prdata_o <= {28'h000_0000, irq_stat_reg};
          `PPA_OFF_IRQ_MASK: prdata_o <= {28'h000_0000, irq_mask_reg};
          default: prdata_o <= mapped ?
            {24'h00_0000, in_buf_reg[cpu_slot]} : 32'h0000_0000;
        endcase
      end
    end
  end
  // pad outputs, registered
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      addr_pads_o <= 16'h0000;
      addr_pad_func_o <= 16'h0000;
      chip_select_out_o <= 1'b0;
      input_threshold_select_o <= 1'b0;
      calendar_pin_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      addr_pads_o <= {addr_reg[`PPA_ADDR_TOP],
        (ctrl_reg[3:2] == `PPA_CSF_SELECT) ? addr_reg[`PPA_ADDR_CS] :
        addr_reg[`PPA_ADDR_CS], addr_reg[13:0]};
      addr_pad_func_o <= {1'b0, pen_eff[`PPA_PEN_SEL], 3'b000,
        pen_eff[10:0]};
      chip_select_out_o <= pen_eff[`PPA_PEN_SEL] &
        (ctrl_reg[3:2] == `PPA_CSF_SELECT) & addr_reg[`PPA_ADDR_CS];
      input_threshold_select_o <= pad_reg[`PPA_PAD_TTL];
      calendar_pin_o <= calendar_out_enable_i &
        (pad_reg[`PPA_PAD_CAL] ? cal_second_i : cal_alarm_i);
      irq_o <= |((irq_stat_reg | ev) & irq_mask_reg);
    end
  end
endmodule // ppa_port
`default_nettype wire

/* verif/ppa_port_chk.sv */
`include "ppa_map.vh"
`default_nettype none
module ppa_port_chk (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic calendar_out_enable_i,
  input wire logic calendar_pin_o,
  input wire logic [15:0] addr_pads_o,
  input wire logic [15:0] addr_pad_func_o,
  input wire logic input_threshold_select_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic wr;
  assign wr = psel_i && penable_i && pwrite_i;
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && !penable_i))
    else $error("ready without setup");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_func_unimpl: assert property ((addr_pad_func_o & 16'hB800) == 0)
    else $error("unowned pad claimed");
  a_cal_gated: assert property (!$past(calendar_out_enable_i) |-> !calendar_pin_o)
    else $error("calendar pin driven while off");
  a_ttl_by_write: assert property ($changed(input_threshold_select_o) |->
    $past(wr && paddr_i == `PPA_OFF_PAD, 1) || $past(wr && paddr_i == `PPA_OFF_PAD, 2))
    else $error("threshold moved without write");
  a_pads_by_write: assert property ($changed(addr_pads_o) |->
    $past(wr && paddr_i == `PPA_OFF_ADDR, 1) || $past(wr && paddr_i == `PPA_OFF_ADDR, 2) ||
    $past(wr && paddr_i == `PPA_OFF_CTRL, 1) || $past(wr && paddr_i == `PPA_OFF_CTRL, 2))
    else $error("address pads moved without write");
endmodule // ppa_port_chk
bind ppa_port ppa_port_chk i_ppa_port_chk (.*);
`default_nettype wire

/* verif/ppa_host_model.sv */
`default_nettype none
module ppa_host_model (
  input wire logic clk_i,
  output var logic wr_o,
  output var logic rd_o,
  output var logic [1:0] addr_o,
  output var logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wr_o, rd_o, addr_o, data_o} = 12'h000;
  end
  // strobe held well past the two-flop sync, then a long low gap
  task automatic cyc(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    data_o <= d;
    @(posedge clk_i);
    wr_o <= w;
    rd_o <= !w;
    repeat (5) @(posedge clk_i);
    {wr_o, rd_o} <= 2'h0;
    data_o <= ~d; // released bus must not look valid
    repeat (4) @(posedge clk_i);
  endtask
endmodule // ppa_host_model
`default_nettype wire

/* verif/tb_top.sv */
`include "ppa_map.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 0, rst_b_i = 0, psel = 0, pen = 0, pwr = 0, err;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, r, x;
  logic prdy, hwr, hrd, csec = 1, calm = 0, cen = 1, cs, ttl, calp, irq;
  logic re;
  logic [1:0] ha;
  logic [7:0] hd, hq;
  logic [15:0] pads, func;
  int n_errors = 0, checked = 0, i, ib[4];
  always #5 core_clk_i = ~core_clk_i;
  ppa_port i_ppa_port (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(err),
    .host_wr_i(hwr), .host_rd_i(hrd), .host_addr_i(ha), .host_data_i(hd),
    .host_data_o(hq), .cal_second_i(csec), .cal_alarm_i(calm),
    .calendar_out_enable_i(cen), .calendar_pin_o(calp),
    .addr_pads_o(pads), .addr_pad_func_o(func), .chip_select_out_o(cs),
    .input_threshold_select_o(ttl), .irq_o(irq));
  ppa_host_model i_ppa_host_model (.clk_i(core_clk_i), .wr_o(hwr),
    .rd_o(hrd), .addr_o(ha), .data_o(hd));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
    @(posedge core_clk_i);
    pen <= 1;
    do @(posedge core_clk_i); while (prdy !== 1'b1 && n++ < 20);
    if (prdy !== 1'b1) n_errors++;
    r = prd;
    re = err;
    {psel, pen} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0000_0000);
    chk("prdata", r, e);
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1;
    rd(`PPA_OFF_STAT, 32'h0000_008F);
    apb(1, `PPA_OFF_CTRL, 32'h0000_0039);
    x = 32'h0001_0807;
    for (i = 0; i < 4; i++) begin
      x = lfsr(x);
      apb(1, `PPA_OFF_PEN, x);
      rd(`PPA_OFF_PEN, x & 32'h0000_47FF);
      chk("func", func, x[15:0] & 16'h47FF);
      apb(1, `PPA_OFF_ADDR, x);
      rd(`PPA_OFF_ADDR, x[15:0]);
      chk("pads", pads, x[15:0]);
      chk("cs", cs, x[14]);
    end
    for (i = 0; i < 3; i++) begin
      cen <= (i < 2);
      apb(1, `PPA_OFF_PAD, i ? 32'hFFFF_FFFF : 32'h0000_0000);
      rd(`PPA_OFF_PAD, i ? 32'h0000_0003 : 32'h0000_0000);
      chk("ttl", ttl, i != 0);
      chk("cal", calp, i == 1);
    end
    cen <= 1;
    apb(0, 12'h100, 32'h0000_0000);
    chk("err", re, 1'b1);
    apb(1, `PPA_OFF_IRQ_MASK, 32'h0000_0004);
    for (i = 0; i < 4; i++) begin
      x = lfsr(x);
      ib[i] = x[7:0];
      i_ppa_host_model.cyc(1, i[1:0], x[7:0]);
    end
    rd(`PPA_OFF_STAT, 32'h0000_8F8F);
    chk("irq", irq, 1'b1);
    apb(0, `PPA_OFF_IRQ_STAT, 32'h0000_0000);
    chk("slot3", r[2], 1'b1);
    i_ppa_host_model.cyc(1, 2'h0, 8'h00);
    rd(`PPA_OFF_STAT, 32'h0000_CF8F);
    chk("irq", irq, 1'b0);
    for (i = 0; i < 4; i++) rd(12'h040 + 12'(4 * i), ib[i]);
    rd(`PPA_OFF_STAT, 32'h0000_408F);
    apb(1, `PPA_OFF_STAT, 32'h0000_0000);
    rd(`PPA_OFF_STAT, 32'h0000_008F);
    for (i = 0; i < 4; i++) apb(1, 12'h040 + 12'(4 * i), ib[i] ^ 8'h5A);
    rd(`PPA_OFF_STAT, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      i_ppa_host_model.cyc(0, i[1:0], 8'h00);
      chk("host", hq, ib[i] ^ 8'h5A);
    end
    rd(`PPA_OFF_STAT, 32'h0000_008F);
    i_ppa_host_model.cyc(0, 2'h0, 8'h00);
    rd(`PPA_OFF_STAT, 32'h0000_00CF);
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
